//--- design/agen_pkg.sv
// package: constants and carrier types for the data address unit
package agen_pkg;
    localparam int ADDR_W = 23;
    localparam int WORD_W = 16;
    localparam int HIGH_W = 7;
    localparam logic [22:0] IE_FIRST_ADDR = 23'h000000;
    localparam logic [22:0] ACC0_LOW_ADDR = 23'h000008;
    localparam logic [22:0] ACC0_HIGH_ADDR = 23'h000009;
    localparam logic [22:0] AUX_TWO_ADDR = 23'h000012;
    localparam logic [22:0] AUX_THREE_ADDR = 23'h000013;
    localparam logic [6:0] DIRECT_MASK = 7'h7F;
    localparam logic [22:0] ADDR_RESET = 23'h000000;
    localparam int ABS_SHORT_BYTES = 2;
    localparam int ABS_LONG_BYTES = 3;

    // operand modes
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_COEF_INDEX = 4'h1,
        OP_ABS_SHORT = 4'h2,
        OP_ABS_LONG = 4'h3,
        OP_DIRECT = 4'h4,
        OP_AUX_IND = 4'h5,
        OP_COEF_IND = 4'h6
    } op_mode_type;

    // indirect forms
    typedef enum logic [3:0] {
        IF_PLAIN = 4'h0,
        IF_POST_INC = 4'h1,
        IF_POST_DEC = 4'h2,
        IF_PRE_INC = 4'h3,
        IF_PRE_DEC = 4'h4,
        IF_IDX_PLUS = 4'h5,
        IF_IDX_MINUS = 4'h6,
        IF_INDEXED = 4'h7,
        IF_BITREV = 4'h8,
        IF_CONST16 = 4'h9,
        IF_PRE_CONST16 = 4'hA,
        IF_SHORT3 = 4'hB
    } ind_form_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FIRST = 3'b010,
        ST_SECOND = 3'b100
    } agen_state_type;

    typedef struct packed {
        op_mode_type mode;
        ind_form_type form;
        logic is_long;
        logic is_write;
        logic dual_read;
        logic dual_write;
        logic mmap_qual;
        logic parallel_req;
        logic [1:0] ext_bytes;
        logic [23:0] ext_const;
        logic [2:0] short_off;
    } agen_req_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic primary_read;
        logic dedicated_write;
        logic [22:0] addr;
    } bus_req_type;
endpackage

//--- design/data_address_unit.sv
// data address unit: pointer arithmetic and register-map address generation
module data_address_unit
    import agen_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // decoded instruction
    input wire logic req_valid_in,
    input wire agen_req_type req_in,
    // mode bits and pointer sources
    input wire logic legacy_compat_bit_in,
    input wire logic compiler_mode_bit_in,
    input wire logic aux_mode_select_in,
    input wire logic [HIGH_W-1:0] main_page_reg_in,
    input wire logic [WORD_W-1:0] page_pointer_in,
    input wire logic [WORD_W-1:0] index_temp_zero_in,
    input wire logic [WORD_W-1:0] aux_pointer_zero_in,
    input wire logic [ADDR_W-1:0] ext_aux_pointer_in,
    input wire logic [WORD_W-1:0] coef_circ_base_in,
    // pointer load
    input wire logic coef_load_in,
    input wire logic [ADDR_W-1:0] coef_load_value_in,
    // outputs
    output bus_req_type bus_out,
    output logic [ADDR_W-1:0] ext_coef_pointer_out,
    output logic [ADDR_W-1:0] aux_update_out,
    output logic aux_update_valid_out,
    output logic fault_out,
    output logic busy_out
);
    agen_state_type state_reg;
    agen_state_type state_next;
    logic [ADDR_W-1:0] coef_reg;
    logic [ADDR_W-1:0] first_addr_reg;
    logic is_write_reg;
    logic dual_r_reg;
    logic dual_w_reg;
    logic [ADDR_W-1:0] addr_calc;
    logic [ADDR_W-1:0] coef_new;
    logic [ADDR_W-1:0] aux_new;
    logic coef_upd;
    logic aux_upd;
    logic legal;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] step;
    logic [ADDR_W-1:0] k16x;
    logic [ADDR_W-1:0] k23;
    logic [ADDR_W-1:0] abs_short;
    logic [WORD_W-1:0] direct_low;
    logic [WORD_W-1:0] circ_low;
    logic [WORD_W-1:0] idx_sel;
    logic take;
    logic is_long_reg;
    logic [ADDR_W-1:0] coef_next_visible;

    // requests while busy are dropped, not queued; the decoder must wait
    assign take = req_valid_in && (state_reg == ST_IDLE);
    // high seven bits kept, low sixteen offset by circular base
    assign circ_low = coef_reg[WORD_W-1:0] + coef_circ_base_in;
    assign idx_sel = legacy_compat_bit_in ? aux_pointer_zero_in : index_temp_zero_in;
    // 16-bit constant offsets are signed, so they are sign-extended to the full pointer
    assign k16x = {{(ADDR_W-WORD_W){req_in.ext_const[WORD_W-1]}}, req_in.ext_const[WORD_W-1:0]};
    assign k23 = req_in.ext_const[ADDR_W-1:0];
    // main page forms upper bits; software keeps it zero for registers
    assign abs_short = {main_page_reg_in, req_in.ext_const[WORD_W-1:0]};

    // page-relative direct
    // qualifier drops page pointer and main page; compiler bit is ignored then
    always_comb begin
        if (req_in.mmap_qual) begin
            direct_low = {9'h000, req_in.ext_const[6:0] & DIRECT_MASK};
        end else begin
            direct_low = page_pointer_in + {9'h000, req_in.ext_const[6:0] & DIRECT_MASK};
        end
    end

    always_comb begin
        base = ext_aux_pointer_in;
        step = req_in.is_long ? 23'h000002 : 23'h000001;
        addr_calc = ADDR_RESET;
        coef_new = coef_reg;
        aux_new = ext_aux_pointer_in;
        coef_upd = 1'b0;
        aux_upd = 1'b0;
        legal = 1'b1;
        case (req_in.mode)
            OP_COEF_INDEX: begin
                addr_calc = {coef_reg[ADDR_W-1:WORD_W], circ_low};
                coef_new = coef_reg + {7'h00, idx_sel};
                coef_upd = 1'b1;
            end
            OP_ABS_SHORT: begin
                addr_calc = abs_short;
                legal = (req_in.ext_bytes == 2'(ABS_SHORT_BYTES)) && !req_in.parallel_req;
            end
            OP_ABS_LONG: begin
                addr_calc = k23;
                legal = (req_in.ext_bytes == 2'(ABS_LONG_BYTES)) && !req_in.parallel_req;
            end
            OP_DIRECT: begin
                if (req_in.mmap_qual) begin
                    addr_calc = {7'h00, direct_low};
                end else begin
                    addr_calc = {main_page_reg_in, direct_low};
                    // register page unreachable in stack-relative mode
                    legal = !compiler_mode_bit_in;
                end
            end
            OP_AUX_IND: begin
                case (req_in.form)
                    IF_PLAIN: addr_calc = base;
                    IF_POST_INC: begin
                        addr_calc = base;
                        aux_new = base + step;
                        aux_upd = 1'b1;
                    end
                    IF_POST_DEC: begin
                        addr_calc = base;
                        aux_new = base - step;
                        aux_upd = 1'b1;
                    end
                    IF_PRE_INC, IF_PRE_DEC: begin
                        aux_new = (req_in.form == IF_PRE_INC) ? base + step : base - step;
                        addr_calc = aux_new;
                        aux_upd = 1'b1;
                        legal = !aux_mode_select_in;
                    end
                    IF_IDX_PLUS, IF_IDX_MINUS: begin
                        addr_calc = base;
                        aux_new = (req_in.form == IF_IDX_PLUS) ? base + {7'h00, idx_sel}
                                                               : base - {7'h00, idx_sel};
                        aux_upd = 1'b1;
                    end
                    IF_INDEXED: addr_calc = base + {7'h00, idx_sel};
                    IF_BITREV: begin
                        addr_calc = base;
                        legal = !aux_mode_select_in;
                    end
                    IF_CONST16: addr_calc = base + k16x;
                    IF_PRE_CONST16: begin
                        aux_new = base + k16x;
                        addr_calc = aux_new;
                        aux_upd = 1'b1;
                    end
                    IF_SHORT3: begin
                        addr_calc = base + {20'h00000, req_in.short_off};
                        legal = aux_mode_select_in;
                    end
                    default: legal = 1'b0;
                endcase
            end
            OP_COEF_IND: begin
                addr_calc = {coef_reg[ADDR_W-1:WORD_W], circ_low};
                case (req_in.form)
                    IF_PLAIN: coef_upd = 1'b0;
                    IF_POST_INC: begin
                        coef_new = coef_reg + step;
                        coef_upd = 1'b1;
                    end
                    IF_POST_DEC: begin
                        coef_new = coef_reg - step;
                        coef_upd = 1'b1;
                    end
                    IF_CONST16: addr_calc = {coef_reg[ADDR_W-1:WORD_W], circ_low} + k16x;
                    IF_PRE_CONST16: begin
                        coef_new = coef_reg + k16x;
                        coef_upd = 1'b1;
                        addr_calc = {coef_reg[ADDR_W-1:WORD_W], circ_low} + k16x;
                    end
                    default: legal = 1'b0;
                endcase
            end
            default: legal = 1'b0;
        endcase
        // an indirect access whose first word is the first enable register is blocked
        // checked on the final address, so offsets landing on zero are refused too
        if ((req_in.mode == OP_AUX_IND || req_in.mode == OP_COEF_IND ||
             req_in.mode == OP_COEF_INDEX) && addr_calc == IE_FIRST_ADDR) begin
            legal = 1'b0;
        end
    end

    // one state per word of the access
    // busy stays high through the last word, so the next request waits a cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (take && legal) state_next = ST_FIRST;
            ST_FIRST: state_next = is_long_reg ? ST_SECOND : ST_IDLE;
            ST_SECOND: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            first_addr_reg <= ADDR_RESET;
            is_long_reg <= 1'b0;
            is_write_reg <= 1'b0;
            dual_r_reg <= 1'b0;
            dual_w_reg <= 1'b0;
        end else if (take && legal) begin
            first_addr_reg <= addr_calc;
            is_long_reg <= req_in.is_long;
            is_write_reg <= req_in.is_write;
            dual_r_reg <= req_in.dual_read && !req_in.is_long;
            dual_w_reg <= req_in.dual_write && !req_in.is_long;
        end
    end

    // pointer updates happen at acceptance; access words follow from the latched address
    // a load from the decoder wins over a post-modify in the same cycle
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            coef_reg <= ADDR_RESET;
        end else if (coef_load_in) begin
            coef_reg <= coef_load_value_in;
        end else if (take && legal && coef_upd) begin
            coef_reg <= coef_new;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            aux_update_out <= ADDR_RESET;
            aux_update_valid_out <= 1'b0;
            fault_out <= 1'b0;
        end else begin
            // write-back value follows the decode; only the strobe is gated
            aux_update_out <= aux_new;
            aux_update_valid_out <= take && legal && aux_upd;
            fault_out <= take && !legal;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            bus_out <= '0;
        end else begin
            bus_out.valid <= (state_next == ST_FIRST) || (state_next == ST_SECOND);
            if (state_next == ST_FIRST) begin
                bus_out.addr <= addr_calc;
                bus_out.write <= req_in.is_write;
                bus_out.primary_read <= req_in.dual_read && !req_in.is_long;
                bus_out.dedicated_write <= req_in.dual_write && !req_in.is_long;
            end else if (state_next == ST_SECOND) begin
                // partner word of the aligned pair
                // accumulator halves at 08h and 09h pair the same way
                bus_out.addr <= first_addr_reg[0] ? first_addr_reg - 23'h000001
                                                  : first_addr_reg + 23'h000001;
                bus_out.write <= is_write_reg;
                bus_out.primary_read <= dual_r_reg;
                bus_out.dedicated_write <= dual_w_reg;
            end else begin
                // address holds while idle to save toggling
                bus_out.write <= 1'b0;
                bus_out.primary_read <= 1'b0;
                bus_out.dedicated_write <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ext_coef_pointer_out <= ADDR_RESET;
            busy_out <= 1'b0;
        end else begin
            ext_coef_pointer_out <= coef_next_visible;
            busy_out <= state_next != ST_IDLE;
        end
    end

    // pointer output shows the value the register takes at this edge
    assign coef_next_visible = coef_load_in ? coef_load_value_in :
                               (take && legal && coef_upd) ? coef_new : coef_reg;
endmodule

//--- testbench/mmr_agen_properties.sv
// checker: word pairing, refusals and address relations of the address unit
module mmr_agen_properties
    import agen_pkg::*;
(
    // watched ports
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic req_valid_in,
    input wire agen_req_type req_in,
    input wire logic legacy_compat_bit_in,
    input wire logic [WORD_W-1:0] index_temp_zero_in,
    input wire logic [WORD_W-1:0] aux_pointer_zero_in,
    input wire logic [ADDR_W-1:0] ext_aux_pointer_in,
    input wire logic coef_load_in,
    input wire bus_req_type bus_out,
    input wire logic [ADDR_W-1:0] ext_coef_pointer_out,
    input wire logic fault_out,
    input wire logic busy_out
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    logic acc;
    logic islong;
    logic [6:0] doff;
    logic [22:0] kaddr;
    logic [15:0] step;
    assign acc = req_valid_in && !busy_out;
    assign islong = req_in.is_long;
    assign doff = req_in.ext_const[6:0];
    assign kaddr = req_in.ext_const[22:0];
    assign step = legacy_compat_bit_in ? aux_pointer_zero_in : index_temp_zero_in;
    sequence s_first;
        bus_out.valid && !$past(busy_out) && $past(islong);
    endsequence
    sequence s_second;
        bus_out.valid && busy_out && bus_out.addr == ($past(bus_out.addr[0]) ?
            $past(bus_out.addr) - 23'h000001 : $past(bus_out.addr) + 23'h000001);
    endsequence
    property p_long_pair;
        s_first |=> s_second;
    endproperty
    a_long_pair: assert property (p_long_pair) else $error("long pair address wrong");
    property p_two_words;
        busy_out ##1 busy_out |=> !busy_out;
    endproperty
    a_two_words: assert property (p_two_words) else $error("busy beyond two words");
    property p_abs_short;
        acc && req_in.mode == OP_ABS_SHORT && !req_in.parallel_req && req_in.ext_bytes == 2'h2
            |=> bus_out.valid ##1 bus_out.valid == $past(islong, 2);
    endproperty
    a_abs_short: assert property (p_abs_short) else $error("word count wrong");
    property p_fault_silent;
        fault_out |-> !bus_out.valid && !busy_out;
    endproperty
    a_fault_silent: assert property (p_fault_silent) else $error("refused yet issued");
    property p_abs_parallel;
        acc && req_in.parallel_req && (req_in.mode == OP_ABS_SHORT || req_in.mode == OP_ABS_LONG)
            |=> fault_out;
    endproperty
    a_abs_parallel: assert property (p_abs_parallel) else $error("parallel not refused");
    property p_ind_zero;
        acc && req_in.mode == OP_AUX_IND && req_in.form == IF_PLAIN
            && ext_aux_pointer_in == 23'h000000 |=> fault_out;
    endproperty
    a_ind_zero: assert property (p_ind_zero) else $error("address zero reached");
    property p_mmap_direct;
        acc && req_in.mode == OP_DIRECT && req_in.mmap_qual && !req_in.parallel_req
            |=> bus_out.valid && bus_out.addr == {16'h0000, $past(doff)};
    endproperty
    a_mmap_direct: assert property (p_mmap_direct) else $error("direct base wrong");
    property p_abs_long;
        acc && req_in.mode == OP_ABS_LONG && !req_in.parallel_req && req_in.ext_bytes == 2'h3
            |=> bus_out.valid && bus_out.addr == $past(kaddr);
    endproperty
    a_abs_long: assert property (p_abs_long) else $error("long constant address wrong");
    property p_coef_index;
        acc && req_in.mode == OP_COEF_INDEX && !coef_load_in && !step[15]
            && ext_coef_pointer_out != 23'h000000 |=> bus_out.addr == $past(ext_coef_pointer_out)
            && ext_coef_pointer_out == $past(ext_coef_pointer_out) + {7'h00, $past(step)};
    endproperty
    a_coef_index: assert property (p_coef_index) else $error("coef post-modify wrong");
endmodule

bind data_address_unit mmr_agen_properties u_props(.core_clk_in, .reset_in, .req_valid_in,
    .req_in, .legacy_compat_bit_in, .index_temp_zero_in, .aux_pointer_zero_in,
    .ext_aux_pointer_in, .coef_load_in, .bus_out, .ext_coef_pointer_out, .fault_out, .busy_out);

//--- testbench/operand_source.sv
// decoder model: issues one operand request and logs the bus words it causes
module operand_source
    import agen_pkg::*;
(
    // observed
    input wire logic core_clk_in,
    input wire bus_req_type bus_in,
    input wire logic fault_in,
    input wire logic aux_valid_in,
    input wire logic [ADDR_W-1:0] aux_in,
    // driven
    output logic req_valid_out,
    output agen_req_type req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    bus_req_type words[$];
    int faults;
    logic [ADDR_W-1:0] aux_last;
    initial begin
        req_valid_out = 1'b0;
        req_out = '0;
        faults = 0;
    end
    always @(posedge core_clk_in) begin
        if (bus_in.valid)
            words.push_back(bus_in);
        if (fault_in)
            faults++;
        if (aux_valid_in)
            aux_last = aux_in;
    end
    // idle gap lets a long pair finish before the next request
    task automatic issue(input agen_req_type r);
        @(negedge core_clk_in);
        req_out = r;
        req_valid_out = 1'b1;
        @(negedge core_clk_in);
        req_valid_out = 1'b0;
        req_out = ~r;  // released fields must not look valid
        repeat (3) @(negedge core_clk_in);
    endtask
endmodule

//--- testbench/tb_top.sv
// testbench: operand requests checked word by word
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top
    import agen_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in, reset_in, req_valid_in, legacy_compat_bit_in, compiler_mode_bit_in;
    logic aux_mode_select_in, coef_load_in, aux_update_valid_out, fault_out, busy_out;
    agen_req_type req_in;
    logic [HIGH_W-1:0] main_page_reg_in;
    logic [WORD_W-1:0] page_pointer_in, index_temp_zero_in, aux_pointer_zero_in, coef_circ_base_in;
    logic [ADDR_W-1:0] ext_aux_pointer_in, coef_load_value_in, ext_coef_pointer_out, aux_update_out;
    bus_req_type bus_out;
    int n_fail, compares, cycles;
    data_address_unit u_data_address_unit(.core_clk_in, .reset_in, .req_valid_in, .req_in,
        .legacy_compat_bit_in, .compiler_mode_bit_in, .aux_mode_select_in, .main_page_reg_in,
        .page_pointer_in, .index_temp_zero_in, .aux_pointer_zero_in, .ext_aux_pointer_in,
        .coef_circ_base_in, .coef_load_in, .coef_load_value_in, .bus_out, .ext_coef_pointer_out,
        .aux_update_out, .aux_update_valid_out, .fault_out, .busy_out);
    operand_source u_operand_source(.core_clk_in, .bus_in(bus_out), .fault_in(fault_out),
        .aux_valid_in(aux_update_valid_out), .aux_in(aux_update_out),
        .req_valid_out(req_valid_in), .req_out(req_in));
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function automatic agen_req_type mk(op_mode_type m, ind_form_type f, logic lng, logic mm,
        logic [23:0] k);
        agen_req_type r;
        r = '0;
        r.mode = m;
        r.form = f;
        r.is_long = lng;
        r.mmap_qual = mm;
        r.ext_bytes = (m == OP_ABS_LONG) ? 2'h3 : (m == OP_ABS_SHORT) ? 2'h2 : 2'h0;
        r.ext_const = k;
        return r;
    endfunction
    task automatic go(agen_req_type r, int nw, logic [22:0] a0, logic [22:0] a1, int f);
        u_operand_source.words.delete();
        u_operand_source.faults = 0;
        u_operand_source.issue(r);
        `CHK(u_operand_source.words.size(), nw)
        if (nw > 0)
            `CHK(u_operand_source.words[0].addr, a0)
        if (nw > 1)
            `CHK(u_operand_source.words[1].addr, a1)
        `CHK(u_operand_source.faults, f)
        `CHK(busy_out, 1'b0)
    endtask
    initial begin
        agen_req_type r;
        {reset_in, legacy_compat_bit_in, compiler_mode_bit_in, aux_mode_select_in} = 4'h8;
        main_page_reg_in = 7'h00;
        page_pointer_in = 16'h0010;
        index_temp_zero_in = 16'h0004;
        aux_pointer_zero_in = 16'h0010;
        coef_circ_base_in = 16'h0000;
        ext_aux_pointer_in = 23'h000000;
        coef_load_value_in = 23'h000021;
        coef_load_in = 1'b0;
        repeat (6) @(posedge core_clk_in);
        @(negedge core_clk_in);
        reset_in = 1'b0;
        coef_load_in = 1'b1;
        @(negedge core_clk_in);
        coef_load_in = 1'b0;
        go(mk(OP_COEF_INDEX, IF_IDX_PLUS, 0, 0, 24'h0), 1, 23'h21, 23'h0, 0);
        `CHK(ext_coef_pointer_out, 23'h000025)
        legacy_compat_bit_in = 1'b1;
        go(mk(OP_COEF_INDEX, IF_IDX_PLUS, 1, 0, 24'h0), 2, 23'h25, 23'h24, 0);
        `CHK(ext_coef_pointer_out, 23'h000035)
        legacy_compat_bit_in = 1'b0;
        go(mk(OP_ABS_SHORT, IF_PLAIN, 1, 0, 24'h12), 2, 23'h12, 23'h13, 0);
        go(mk(OP_ABS_LONG, IF_PLAIN, 1, 0, 24'h8), 2, 23'h8, 23'h9, 0);
        r = mk(OP_ABS_LONG, IF_PLAIN, 0, 0, 24'h8);
        r.parallel_req = 1'b1;
        go(r, 0, 23'h0, 23'h0, 1);
        go(mk(OP_DIRECT, IF_PLAIN, 0, 0, 24'h85), 1, 23'h15, 23'h0, 0);
        {main_page_reg_in, page_pointer_in, compiler_mode_bit_in} = {7'h05, 16'h0300, 1'b1};
        go(mk(OP_DIRECT, IF_PLAIN, 1, 1, 24'h188), 2, 23'h8, 23'h9, 0);
        compiler_mode_bit_in = 1'b0;
        go(mk(OP_AUX_IND, IF_PLAIN, 0, 0, 24'h0), 0, 23'h0, 23'h0, 1);
        ext_aux_pointer_in = 23'h000012;
        aux_mode_select_in = 1'b1;
        go(mk(OP_AUX_IND, IF_POST_INC, 0, 1, 24'h0), 1, 23'h12, 23'h0, 0);
        `CHK(u_operand_source.aux_last, 23'h000013)
        go(mk(OP_AUX_IND, IF_BITREV, 0, 1, 24'h0), 0, 23'h0, 23'h0, 1);
        go(mk(OP_COEF_IND, IF_IDX_PLUS, 0, 1, 24'h0), 0, 23'h0, 23'h0, 1);
        r = mk(OP_AUX_IND, IF_SHORT3, 0, 1, 24'h0);
        r.short_off = 3'h1;
        go(r, 1, 23'h13, 23'h0, 0);
        go(mk(OP_COEF_IND, IF_CONST16, 0, 1, 24'h3), 1, 23'h38, 23'h0, 0);
        `CHK(ext_coef_pointer_out, 23'h000035)
        go(mk(OP_COEF_IND, IF_PRE_CONST16, 0, 1, 24'h2), 1, 23'h37, 23'h0, 0);
        `CHK(ext_coef_pointer_out, 23'h000037)
        aux_mode_select_in = 1'b0;
        ext_aux_pointer_in = 23'h000013;
        go(r, 0, 23'h0, 23'h0, 1);
        r = mk(OP_AUX_IND, IF_PLAIN, 0, 0, 24'h0);
        r.dual_read = 1'b1;
        go(r, 1, 23'h13, 23'h0, 0);
        `CHK(u_operand_source.words[0].primary_read, 1'b1)
        r.dual_read = 1'b0;
        r.dual_write = 1'b1;
        r.is_write = 1'b1;
        go(r, 1, 23'h13, 23'h0, 0);
        `CHK({u_operand_source.words[0].write, u_operand_source.words[0].dedicated_write}, 2'b11)
        tally_and_finish();
    end
endmodule
